// [rtl/adcsel_top.sv]
`timescale 1ns/100ps
`default_nettype none
module adcsel_top #(
    parameter int CONVERT_COMMAND_DIV = adcsel_pkg::CONVERT_COMMAND_DIV
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [2:0] compareHigh,
    output var adcsel_pkg::adcsel_route_s holdRoute,
    output logic mainHoldTrack,
    output logic asyncHoldStrobe,
    output logic [7:0] dacLevel,
    output logic [1:0] gainSelect,
    output logic [35:0] sarTrial
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    // Divider counter is 8 bits; the cycle must fit its time budget
    if (CONVERT_COMMAND_DIV < 1 || CONVERT_COMMAND_DIV > 256 ||
        adcsel_pkg::PULSE_SPAN * CONVERT_COMMAND_DIV > adcsel_pkg::CYCLE_CLKS)
    begin : g_bad_div
        $error("CONVERT_COMMAND_DIV out of range");
    end

    localparam logic [7:0] DIV_LAST = 8'(CONVERT_COMMAND_DIV - 1);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    adcsel_pkg::adcsel_state_e state_reg;
    logic [7:0] divCnt_reg;
    logic [3:0] pulseCnt_reg;
    logic [12:0] setupNext_reg;
    logic [12:0] setupShift_reg;
    logic [12:0] setupActive_reg;
    logic [1:0] convCount_reg;
    logic asyncOk_reg;
    logic [11:0] sar_reg [3];
    logic [11:0] result_reg [3];
    logic wrPend_reg;
    logic [7:0] addr_reg;
    logic [31:0] rdata;
    logic startConv;
    logic pulseEvt;
    logic [3:0] nextPulse;
    logic [3:0] bitIdx;
    logic [3:0] shiftIdx;
    logic resolveBit;
    logic shiftBit;
    logic lastPulse;
    logic [12:0] shiftNext;
    logic busWrite;
    adcsel_pkg::adcsel_route_s decoded;

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    // Zero wait state, always OKAY; only word writes take effect
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPend_reg <= 1'b0;
            addr_reg <= 8'h00;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready) begin
                wrPend_reg <= hsel && htrans[1] && hwrite &&
                    (hsize == adcsel_pkg::HSIZE_WORD);
                addr_reg <= haddr[7:0];
            end
        end
    end

    // Read data is captured at the address phase, unmapped reads zero
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (haddr[7:0])
            adcsel_pkg::REG_CONTROL:
                rdata[adcsel_pkg::CTRL_ASYNC_TRACK_BIT] = asyncHoldStrobe;
            adcsel_pkg::REG_SETUP_NEXT: rdata[12:0] = setupNext_reg;
            adcsel_pkg::REG_STATUS: begin
                rdata[adcsel_pkg::STAT_BUSY_BIT] =
                    (state_reg == adcsel_pkg::ADCSEL_CONVERT_COMMAND);
                rdata[adcsel_pkg::STAT_VALID_BIT] =
                    (convCount_reg == adcsel_pkg::VALID_AFTER);
                rdata[adcsel_pkg::STAT_ASYNC_OK_BIT] = asyncOk_reg;
                rdata[adcsel_pkg::STAT_COUNT_LSB +: 2] = convCount_reg;
            end
            adcsel_pkg::REG_SETUP_ACTIVE: rdata[12:0] = setupActive_reg;
            adcsel_pkg::REG_ROUTE: rdata = 32'(holdRoute);
            adcsel_pkg::REG_RESULT1: rdata[11:0] = result_reg[0];
            adcsel_pkg::REG_RESULT2: rdata[11:0] = result_reg[1];
            adcsel_pkg::REG_RESULT3: rdata[11:0] = result_reg[2];
            adcsel_pkg::REG_DAC: rdata[7:0] = dacLevel;
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= rdata;
        end
    end

    assign busWrite = wrPend_reg;

    // ----------------------------------------------------------------
    // Software controls
    // ----------------------------------------------------------------
    // Convert command is ignored while a cycle is running
    assign startConv = busWrite && (addr_reg == adcsel_pkg::REG_CONTROL) &&
        hwdata[adcsel_pkg::CTRL_CONVERT_BIT] &&
        (state_reg == adcsel_pkg::ADCSEL_IDLE);

    // Async strobe level: high tracks, low holds
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            asyncHoldStrobe <= adcsel_pkg::CTRL_ASYNC_TRACK_RST;
        end else if (busWrite && addr_reg == adcsel_pkg::REG_CONTROL) begin
            asyncHoldStrobe <= hwdata[adcsel_pkg::CTRL_ASYNC_TRACK_BIT];
        end
    end

    // Next setup word, written any time; shifted in bit by bit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            setupNext_reg <= adcsel_pkg::SETUP_RST;
        end else if (busWrite &&
                     addr_reg == adcsel_pkg::REG_SETUP_NEXT) begin
            setupNext_reg <= hwdata[12:0];
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    // Pulse 1 coincides with the command, later pulses every CONVERT_COMMAND_DIV
    assign pulseEvt = (state_reg == adcsel_pkg::ADCSEL_CONVERT_COMMAND) &&
        (divCnt_reg == DIV_LAST);
    assign nextPulse = pulseCnt_reg + 4'h1;
    assign lastPulse = pulseEvt && (nextPulse == adcsel_pkg::PULSE_LAST);
    assign resolveBit = pulseEvt &&
        (nextPulse >= adcsel_pkg::PULSE_SHIFT_FIRST) &&
        (nextPulse <= adcsel_pkg::PULSE_LAST_BIT);
    assign shiftBit = pulseEvt &&
        (nextPulse >= adcsel_pkg::PULSE_SHIFT_FIRST);
    assign bitIdx = adcsel_pkg::PULSE_LAST_BIT - nextPulse;
    assign shiftIdx = nextPulse - adcsel_pkg::PULSE_SHIFT_FIRST;
    // Serial setup input arrives least significant bit first
    assign shiftNext = {setupNext_reg[shiftIdx], setupShift_reg[12:1]};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= adcsel_pkg::ADCSEL_IDLE;
            divCnt_reg <= 8'h00;
            pulseCnt_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                adcsel_pkg::ADCSEL_IDLE: begin
                    if (startConv) begin
                        state_reg <= adcsel_pkg::ADCSEL_CONVERT_COMMAND;
                        divCnt_reg <= 8'h00;
                        pulseCnt_reg <= adcsel_pkg::PULSE_FIRST;
                    end
                end
                adcsel_pkg::ADCSEL_CONVERT_COMMAND: begin
                    if (pulseEvt) begin
                        divCnt_reg <= 8'h00;
                        pulseCnt_reg <= nextPulse;
                        if (lastPulse) begin
                            state_reg <= adcsel_pkg::ADCSEL_IDLE;
                        end
                    end else begin
                        divCnt_reg <= divCnt_reg + 8'h01;
                    end
                end
            endcase
        end
    end

    // Main holds track while idle and hold through the cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mainHoldTrack <= 1'b1;
        end else if (startConv) begin
            mainHoldTrack <= 1'b0;
        end else if (lastPulse) begin
            mainHoldTrack <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Setup register, double buffered
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            setupShift_reg <= adcsel_pkg::SETUP_RST;
            setupActive_reg <= adcsel_pkg::SETUP_RST;
        end else if (shiftBit) begin
            setupShift_reg <= shiftNext;
            if (lastPulse) begin
                setupActive_reg <= shiftNext;
            end
        end
    end

    // DAC takes the freshly received word at the last pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dacLevel <= 8'h00;
        end else if (lastPulse) begin
            dacLevel <= shiftNext[adcsel_pkg::DAC_LSB +: 8];
        end
    end

    // ----------------------------------------------------------------
    // Routing and gain, applied at conversion start
    // ----------------------------------------------------------------
    adcsel_decoder u_decoder (
        .selCode(setupActive_reg[adcsel_pkg::SEL_LSB +: 3]),
        .ch1AsyncHeld(holdRoute.ch1AsyncIn),
        .ch2AsyncHeld(holdRoute.ch2AsyncIn),
        .route(decoded)
    );

    // Reset leaves the async hold inputs open until a select code
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            holdRoute <= '0;
            gainSelect <= 2'h0;
        end else if (startConv) begin
            holdRoute <= decoded;
            gainSelect <= setupActive_reg[adcsel_pkg::GAIN_LSB +: 2];
        end
    end

    // Notes whether the async strobe was already holding at the command
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            asyncOk_reg <= 1'b0;
        end else if (startConv) begin
            asyncOk_reg <= !asyncHoldStrobe;
        end
    end

    // Completed cycles, saturating; results trusted from the third
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            convCount_reg <= 2'h0;
        end else if (lastPulse &&
                     convCount_reg != adcsel_pkg::VALID_AFTER) begin
            convCount_reg <= convCount_reg + 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // Successive approximation, one per channel
    // ----------------------------------------------------------------
    for (genvar c = 0; c < 3; c++) begin : g_ch
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                sar_reg[c] <= 12'h000;
            end else if (startConv) begin
                sar_reg[c] <= adcsel_pkg::SAR_START;
            end else if (resolveBit) begin
                // Keep the trial bit if input is at or above the trial
                sar_reg[c][bitIdx] <= compareHigh[c];
                if (bitIdx != 4'h0) begin
                    sar_reg[c][bitIdx - 4'h1] <= 1'b1;
                end
            end
        end

        // Offset binary to two's complement by flipping the MSB
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                result_reg[c] <= 12'h000;
            end else if (lastPulse) begin
                result_reg[c] <= sar_reg[c] ^ adcsel_pkg::TWOS_FLIP;
            end
        end

        assign sarTrial[c*12 +: 12] = sar_reg[c];
    end

endmodule : adcsel_top
`default_nettype wire

// [rtl/adcsel_pkg.sv]
// How it works
// - Input select bits 10-12 steer all switches
// - Code 111 converts first inputs, main holds
// - Codes 100-110 convert second, aux holds sample
// - Code 011 converts third inputs from aux holds
// - Code 010 third via main, ch1 aux samples
// - Codes 000/001 convert ch3 fourth input
// - Codes 100/101/110 set async hold inputs
// - Other codes keep async hold inputs unchanged
// - DAC level is setup bits 0 to 7
// - Converter clock at most 2.1MHz, 6.6us
// - Twelve bit SAR result, two's complement
// - Setup word shifted in, double buffered
// - DAC field transferred on fourteenth pulse
// - Gain field bits 8-9 for all amplifiers
// - Results valid from third conversion onward
package adcsel_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 20;
    localparam int CLK_KHZ = 50000;
    localparam int CONVERT_COMMAND_CLK_MAX_KHZ = 2100;
    // Least pulse period, rounded up so the pulse rate never exceeds max
    localparam int CONVERT_COMMAND_DIV =
        (CLK_KHZ + CONVERT_COMMAND_CLK_MAX_KHZ - 1) / CONVERT_COMMAND_CLK_MAX_KHZ;
    localparam int CYCLE_NS = 6600;
    localparam int CYCLE_CLKS = CYCLE_NS / CLK_NS;
    localparam int PULSE_SPAN = 13;

    // ----------------------------------------------------------------
    // Conversion pulse numbers
    // ----------------------------------------------------------------
    localparam logic [3:0] PULSE_FIRST = 4'h1;
    localparam logic [3:0] PULSE_SHIFT_FIRST = 4'h2;
    localparam logic [3:0] PULSE_LAST_BIT = 4'hd;
    localparam logic [3:0] PULSE_LAST = 4'he;

    // ----------------------------------------------------------------
    // Setup word layout
    // ----------------------------------------------------------------
    localparam int SETUP_BITS = 13;
    localparam int DAC_LSB = 0;
    localparam int DAC_W = 8;
    localparam int GAIN_LSB = 8;
    localparam int GAIN_W = 2;
    localparam int SEL_LSB = 10;
    localparam int SEL_W = 3;
    localparam logic [12:0] SETUP_RST = 13'h0000;

    // Input select codes
    localparam logic [2:0] SEL_UNDEF = 3'h0;
    localparam logic [2:0] SEL_ASYNC = 3'h1;
    localparam logic [2:0] SEL_THIRD_MAIN = 3'h2;
    localparam logic [2:0] SEL_THIRD_AUX = 3'h3;
    localparam logic [2:0] SEL_SECOND_OPEN = 3'h4;
    localparam logic [2:0] SEL_SECOND_THIRD = 3'h5;
    localparam logic [2:0] SEL_SECOND_SECOND = 3'h6;
    localparam logic [2:0] SEL_FIRST = 3'h7;

    // Async hold input selection
    localparam logic [1:0] ASEL_OPEN = 2'h0;
    localparam logic [1:0] ASEL_SECOND = 2'h1;
    localparam logic [1:0] ASEL_THIRD = 2'h2;

    // One-hot main hold inputs and converter sources
    localparam logic [2:0] IN_NONE = 3'h0;
    localparam logic [2:0] IN_FIRST = 3'h1;
    localparam logic [2:0] IN_SECOND = 3'h2;
    localparam logic [2:0] IN_THIRD = 3'h4;
    localparam logic [3:0] IN3_FIRST = 4'h1;
    localparam logic [3:0] IN3_SECOND = 4'h2;
    localparam logic [3:0] IN3_THIRD = 4'h4;
    localparam logic [3:0] IN3_FOURTH = 4'h8;
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_MAIN = 3'h1;
    localparam logic [2:0] SRC_AUX = 3'h2;
    localparam logic [2:0] SRC_ASYNC = 3'h4;

    // ----------------------------------------------------------------
    // Converter result
    // ----------------------------------------------------------------
    localparam int RESULT_BITS = 12;
    localparam logic [11:0] SAR_START = 12'h800;
    localparam logic [11:0] TWOS_FLIP = 12'h800;
    localparam logic [1:0] VALID_AFTER = 2'h3;

    // ----------------------------------------------------------------
    // Register map, byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_SETUP_NEXT = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_SETUP_ACTIVE = 8'h0c;
    localparam logic [7:0] REG_ROUTE = 8'h10;
    localparam logic [7:0] REG_RESULT1 = 8'h14;
    localparam logic [7:0] REG_RESULT2 = 8'h18;
    localparam logic [7:0] REG_RESULT3 = 8'h1c;
    localparam logic [7:0] REG_DAC = 8'h20;
    localparam int CTRL_CONVERT_BIT = 0;
    localparam int CTRL_ASYNC_TRACK_BIT = 1;
    localparam logic CTRL_ASYNC_TRACK_RST = 1'b1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_VALID_BIT = 1;
    localparam int STAT_ASYNC_OK_BIT = 2;
    localparam int STAT_COUNT_LSB = 4;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] ch1MainIn;
        logic [2:0] ch2MainIn;
        logic [3:0] ch3In;
        logic [2:0] ch1AdcSrc;
        logic [2:0] ch2AdcSrc;
        logic ch1AuxSample;
        logic ch2AuxSample;
        logic [1:0] ch1AsyncIn;
        logic [1:0] ch2AsyncIn;
    } adcsel_route_s;

    typedef enum logic [1:0] {
        ADCSEL_IDLE = 2'b01,
        ADCSEL_CONVERT_COMMAND = 2'b10
    } adcsel_state_e;

endpackage : adcsel_pkg

// [rtl/adcsel_decoder.sv]
`timescale 1ns/100ps
`default_nettype none
module adcsel_decoder (
    input wire logic [2:0] selCode,
    input wire logic [1:0] ch1AsyncHeld,
    input wire logic [1:0] ch2AsyncHeld,
    output adcsel_pkg::adcsel_route_s route
);

    // ----------------------------------------------------------------
    // Input select decode
    // ----------------------------------------------------------------
    // Async inputs default to held values so no-effect codes keep them
    always_comb begin
        route = '0;
        route.ch1AsyncIn = ch1AsyncHeld;
        route.ch2AsyncIn = ch2AsyncHeld;
        unique case (selCode)
            adcsel_pkg::SEL_UNDEF: begin
                route.ch3In = adcsel_pkg::IN3_FOURTH;
                route.ch1AdcSrc = adcsel_pkg::SRC_NONE;
                route.ch2AdcSrc = adcsel_pkg::SRC_NONE;
            end
            adcsel_pkg::SEL_ASYNC: begin
                route.ch3In = adcsel_pkg::IN3_FOURTH;
                route.ch1AdcSrc = adcsel_pkg::SRC_ASYNC;
                route.ch2AdcSrc = adcsel_pkg::SRC_ASYNC;
            end
            adcsel_pkg::SEL_THIRD_MAIN: begin
                route.ch1MainIn = adcsel_pkg::IN_THIRD;
                route.ch2MainIn = adcsel_pkg::IN_THIRD;
                route.ch3In = adcsel_pkg::IN3_THIRD;
                route.ch1AdcSrc = adcsel_pkg::SRC_MAIN;
                route.ch2AdcSrc = adcsel_pkg::SRC_MAIN;
                route.ch1AuxSample = 1'b1;
            end
            adcsel_pkg::SEL_THIRD_AUX: begin
                // Aux holds still carry values from an earlier cycle
                route.ch3In = adcsel_pkg::IN3_THIRD;
                route.ch1AdcSrc = adcsel_pkg::SRC_AUX;
                route.ch2AdcSrc = adcsel_pkg::SRC_AUX;
            end
            adcsel_pkg::SEL_SECOND_OPEN: begin
                route.ch1MainIn = adcsel_pkg::IN_SECOND;
                route.ch2MainIn = adcsel_pkg::IN_SECOND;
                route.ch3In = adcsel_pkg::IN3_SECOND;
                route.ch1AdcSrc = adcsel_pkg::SRC_MAIN;
                route.ch2AdcSrc = adcsel_pkg::SRC_MAIN;
                route.ch1AuxSample = 1'b1;
                route.ch2AuxSample = 1'b1;
                route.ch1AsyncIn = adcsel_pkg::ASEL_OPEN;
                route.ch2AsyncIn = adcsel_pkg::ASEL_OPEN;
            end
            adcsel_pkg::SEL_SECOND_THIRD: begin
                route.ch1MainIn = adcsel_pkg::IN_SECOND;
                route.ch2MainIn = adcsel_pkg::IN_SECOND;
                route.ch3In = adcsel_pkg::IN3_SECOND;
                route.ch1AdcSrc = adcsel_pkg::SRC_MAIN;
                route.ch2AdcSrc = adcsel_pkg::SRC_MAIN;
                route.ch1AuxSample = 1'b1;
                route.ch2AuxSample = 1'b1;
                route.ch1AsyncIn = adcsel_pkg::ASEL_THIRD;
                route.ch2AsyncIn = adcsel_pkg::ASEL_THIRD;
            end
            adcsel_pkg::SEL_SECOND_SECOND: begin
                route.ch1MainIn = adcsel_pkg::IN_SECOND;
                route.ch2MainIn = adcsel_pkg::IN_SECOND;
                route.ch3In = adcsel_pkg::IN3_SECOND;
                route.ch1AdcSrc = adcsel_pkg::SRC_MAIN;
                route.ch2AdcSrc = adcsel_pkg::SRC_MAIN;
                route.ch1AuxSample = 1'b1;
                route.ch2AuxSample = 1'b1;
                // Second hold takes its own channel's second input
                route.ch1AsyncIn = adcsel_pkg::ASEL_SECOND;
                route.ch2AsyncIn = adcsel_pkg::ASEL_SECOND;
            end
            adcsel_pkg::SEL_FIRST: begin
                route.ch1MainIn = adcsel_pkg::IN_FIRST;
                route.ch2MainIn = adcsel_pkg::IN_FIRST;
                route.ch3In = adcsel_pkg::IN3_FIRST;
                route.ch1AdcSrc = adcsel_pkg::SRC_MAIN;
                route.ch2AdcSrc = adcsel_pkg::SRC_MAIN;
            end
        endcase
    end

endmodule : adcsel_decoder
`default_nettype wire

// [testbench/adcsel_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
// ----
// Routing and timing checker
// ----
module adcsel_monitor #(
    parameter int CONVERT_COMMAND_DIV = adcsel_pkg::CONVERT_COMMAND_DIV
) (
    input wire logic clk,
    input wire logic resetn,
    input wire adcsel_pkg::adcsel_route_s holdRoute,
    input wire logic mainHoldTrack,
    input wire logic [7:0] dacLevel,
    input wire logic [1:0] gainSelect
);
    int holdCnt;
    // Hold length in clocks, so the cycle time can be judged at release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            holdCnt <= 0;
        else
            holdCnt <= mainHoldTrack ? 0 : holdCnt + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_start; $fell(mainHoldTrack); endsequence
    sequence s_end; $rose(mainHoldTrack); endsequence
    property p_route; $changed(holdRoute) |-> s_start; endproperty
    a_route: assert property (p_route)
        else $error("route changed outside a start");
    property p_sticky; $changed({holdRoute.ch1AsyncIn, holdRoute.ch2AsyncIn})
        |-> holdRoute.ch1AuxSample && holdRoute.ch2AuxSample; endproperty
    a_sticky: assert property (p_sticky)
        else $error("async inputs moved on a keeping code");
    property p_first; holdRoute.ch3In == adcsel_pkg::IN3_FIRST
        |-> holdRoute.ch1MainIn == adcsel_pkg::IN_FIRST
        && holdRoute.ch2MainIn == adcsel_pkg::IN_FIRST; endproperty
    a_first: assert property (p_first)
        else $error("first inputs not on main holds");
    property p_second; holdRoute.ch3In == adcsel_pkg::IN3_SECOND
        |-> holdRoute.ch1AuxSample && holdRoute.ch2AuxSample; endproperty
    a_second: assert property (p_second)
        else $error("aux holds idle on second inputs");
    property p_async; holdRoute.ch1AdcSrc == adcsel_pkg::SRC_ASYNC
        |-> holdRoute.ch3In == adcsel_pkg::IN3_FOURTH; endproperty
    a_async: assert property (p_async)
        else $error("async conversion without fourth input");
    property p_dac; $changed(dacLevel) |-> s_end; endproperty
    a_dac: assert property (p_dac)
        else $error("dac moved away from cycle end");
    property p_gain; $changed(gainSelect) |-> s_start; endproperty
    a_gain: assert property (p_gain)
        else $error("gain moved away from cycle start");
    property p_len; s_end |-> holdCnt == 13 * CONVERT_COMMAND_DIV; endproperty
    a_len: assert property (p_len)
        else $error("conversion cycle length wrong");
endmodule : adcsel_monitor
bind adcsel_top adcsel_monitor #(.CONVERT_COMMAND_DIV(CONVERT_COMMAND_DIV)) u_mon (
    .clk(clk), .resetn(resetn), .holdRoute(holdRoute),
    .mainHoldTrack(mainHoldTrack), .dacLevel(dacLevel),
    .gainSelect(gainSelect));
`default_nettype wire

// [testbench/adcsel_front_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----
// Comparator front end
// ----
module adcsel_front_model (
    input wire logic [35:0] analogLevel,
    input wire logic [35:0] sarTrial,
    output logic [2:0] compareHigh
);
    // Answers at once; a held level is compared with each trial code
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            compareHigh[c] = analogLevel[c*12+:12] >= sarTrial[c*12+:12];
        end
    end
endmodule : adcsel_front_model
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0, gainSelect;
    logic [2:0] hsize = adcsel_pkg::HSIZE_WORD, compareHigh, pc;
    logic hreadyout, hresp, mainHoldTrack, asyncHoldStrobe;
    logic [7:0] dacLevel;
    logic [35:0] sarTrial;
    logic [12:0] w, prev = 13'h0000;
    logic [3:0] aSel = 4'h0;
    adcsel_pkg::adcsel_route_s holdRoute;
    int errCount = 0, numChecks = 0;
    localparam logic [35:0] LEVELS = {12'h5a3, 12'hfff, 12'h000};
    localparam logic [2:0] CODES [9] = '{3'h7, 3'h5, 3'h2, 3'h3, 3'h1,
        3'h6, 3'h0, 3'h4, 3'h7};
    // Clock at 50 MHz
    always #10 clk = ~clk;
    adcsel_top #(.CONVERT_COMMAND_DIV(2)) u_dut (.clk(clk), .resetn(resetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .compareHigh(compareHigh), .holdRoute(holdRoute),
        .mainHoldTrack(mainHoldTrack), .asyncHoldStrobe(asyncHoldStrobe),
        .dacLevel(dacLevel), .gainSelect(gainSelect), .sarTrial(sarTrial));
    adcsel_front_model u_front (.analogLevel(LEVELS), .sarTrial(sarTrial),
        .compareHigh(compareHigh));
    // ----
    // Bus and check tasks
    // ----
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic endSim();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : endSim
    // Converter source per code: third-channel input, then both sources
    function automatic logic [9:0] srcExp(input logic [2:0] c);
        logic [2:0] s;
        s = c == 1 ? adcsel_pkg::SRC_ASYNC : c == 3 ? adcsel_pkg::SRC_AUX :
            c == 0 ? adcsel_pkg::SRC_NONE : adcsel_pkg::SRC_MAIN;
        return {c == 7 ? adcsel_pkg::IN3_FIRST : c[2] ? adcsel_pkg::IN3_SECOND
            : c[1] ? adcsel_pkg::IN3_THIRD : adcsel_pkg::IN3_FOURTH, s, s};
    endfunction : srcExp
    // Hang guard, well beyond nine short cycles
    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        endSim();
    end
    // Select and gain fields take effect one cycle after the cycle that loads the word; the DAC field at its end
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        bus(1'b0, 8'h40, 32'h0, q);
        chk(q, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        for (int i = 0; i < 9; i++) begin
            w = {CODES[i], i[1:0], i[7:0] * 8'h1d};
            pc = prev[12:10];
            bus(1'b1, adcsel_pkg::REG_SETUP_NEXT, {19'h0, w}, q);
            bus(1'b1, adcsel_pkg::REG_CONTROL, 32'(pc != 1) << 1, q);
            bus(1'b1, adcsel_pkg::REG_CONTROL, {30'h0, pc != 1, 1'b1}, q);
            @(negedge clk);
            aSel = pc == 4 ? 4'h0 : pc == 5 ? 4'ha : pc == 6 ? 4'h5 : aSel;
            chk({22'h0, holdRoute[15:6]}, {22'h0, srcExp(pc)});
            chk({28'h0, holdRoute[3:0]}, {28'h0, aSel});
            if (pc inside {[2:6]})
                chk({30'h0, holdRoute[5:4]}, {30'h0, pc != 3, pc[2]});
            chk({30'h0, gainSelect}, {30'h0, prev[9:8]});
            chk({31'h0, asyncHoldStrobe}, {31'h0, pc != 1});
            for (int n = 0; n < 200 && mainHoldTrack !== 1'b1; n++)
                @(negedge clk);
            chk({31'h0, mainHoldTrack}, 32'h1);
            @(posedge clk);
            chk({24'h0, dacLevel}, {24'h0, w[7:0]});
            bus(1'b0, adcsel_pkg::REG_SETUP_ACTIVE, 32'h0, q);
            chk(q, {19'h0, w});
            bus(1'b0, adcsel_pkg::REG_STATUS, 32'h0, q);
            chk({29'h0, q[2:0]}, {29'h0, pc == 1, i >= 2, 1'b0});
            for (int c = 0; c < 3 && i >= 2; c++) begin
                bus(1'b0, adcsel_pkg::REG_RESULT1 + 8'(4 * c), 32'h0, q);
                chk(q, {20'h0, LEVELS[c*12+:12] ^ 12'h800});
            end
            prev = w;
        end
        endSim();
    end
endmodule : testbench
`default_nettype wire
